// [lmc_lin_node.sv]
module lmc_lin_node
(
  input wire logic ref_clk_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Recessive high between frames, as the bus pull-up leaves it
  initial line_o = 1'b1;

  // Sync frame: start bit, 0x55 lsb first, stop bit
  task automatic send(input int per);
    logic [9:0] frame;
    begin
      frame = {1'b1, 8'h55, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        line_o <= frame[i];
        repeat (per) @(posedge ref_clk_i);
      end
    end
  endtask
endmodule // lmc_lin_node

// [lmc_pkg.sv]
package lmc_pkg;

  localparam int unsigned LMC_PORTS = 2;

  // Software configuration handed to one serial port
  typedef struct packed {
    logic [2:0] fsel;
    logic multiprocessor_enable;
    logic parity_enable;
    logic [7:0] lin_ctl;
  } lmc_port_cfg_s;

  // State reported back by one serial port
  typedef struct packed {
    logic master;
    logic slave;
    logic ab_active;
    logic ab_event;
    logic [15:0] bit_period;
  } lmc_port_stat_s;

  // Autobaud measurement states
  typedef enum logic [2:0] {
    LMC_AB_WAIT = 3'b001,
    LMC_AB_COUNT = 3'b010,
    LMC_AB_DONE = 3'b100
  } lmc_ab_state_e;

endpackage

// [lmc_port.sv]
`include "lmc_regs.svh"

module lmc_port
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire lmc_pkg::lmc_port_cfg_s cfg_i,
  input wire logic rx_i,
  output lmc_pkg::lmc_port_stat_s stat_o
);

  logic sync1_reg;
  logic sync2_reg;
  logic rx_prev_reg;
  logic fall;
  logic in_lin;
  logic master_next;
  logic slave_next;
  logic ab_act_next;
  lmc_pkg::lmc_ab_state_e state_reg;
  lmc_pkg::lmc_ab_state_e state_next;
  logic [`LMC_CNT_W-1:0] cnt_reg;
  logic [`LMC_CNT_W-1:0] cnt_next;
  logic [2:0] falls_reg;
  logic [2:0] falls_next;
  lmc_pkg::lmc_port_stat_s stat_reg;
  lmc_pkg::lmc_port_stat_s stat_next;

  // Falling edge seen only on the second synchroniser stage
  assign fall = rx_prev_reg & ~sync2_reg;
  assign in_lin = (cfg_i.fsel == `LMC_FSEL_LIN);

  // Role decode; the two roles exclude each other and parity modes
  always_comb
  begin
    master_next = in_lin & cfg_i.lin_ctl[`LMC_LIN_MASTER_BIT] & ~cfg_i.multiprocessor_enable
      & ~cfg_i.parity_enable & ~cfg_i.lin_ctl[`LMC_LIN_SLAVE_BIT];
    slave_next = in_lin & cfg_i.lin_ctl[`LMC_LIN_SLAVE_BIT] & ~cfg_i.multiprocessor_enable
      & ~cfg_i.parity_enable & ~cfg_i.lin_ctl[`LMC_LIN_MASTER_BIT];
    ab_act_next = slave_next & cfg_i.lin_ctl[`LMC_AB_EN_BIT];
  end

  // Autobaud: time five falling edges of the sync byte, eight bit times
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    falls_next = falls_reg;
    stat_next = stat_reg;
    stat_next.master = master_next;
    stat_next.slave = slave_next;
    stat_next.ab_active = ab_act_next;
    stat_next.ab_event = 1'b0;
    case (state_reg)
      lmc_pkg::LMC_AB_WAIT:
      begin
        if (ab_act_next && fall)
        begin
          state_next = lmc_pkg::LMC_AB_COUNT;
          cnt_next = '0;
          falls_next = '0;
        end
      end
      lmc_pkg::LMC_AB_COUNT:
      begin
        cnt_next = cnt_reg + `LMC_CNT_W'(1);
        if (!ab_act_next || cnt_reg == `LMC_CNT_MAX)
        begin
          // Disabled or line too slow: drop the attempt
          state_next = lmc_pkg::LMC_AB_WAIT;
        end
        else if (fall)
        begin
          falls_next = falls_reg + 3'h1;
          if (falls_reg + 3'h1 == `LMC_AB_FALLS)
          begin
            state_next = lmc_pkg::LMC_AB_DONE;
            stat_next.bit_period = 16'(cnt_next >> `LMC_PERIOD_SHIFT);
            stat_next.ab_event = cfg_i.lin_ctl[`LMC_AB_IRQ_EN_BIT];
          end
        end
      end
      lmc_pkg::LMC_AB_DONE:
      begin
        state_next = lmc_pkg::LMC_AB_WAIT;
      end
      default:
      begin
        state_next = lmc_pkg::LMC_AB_WAIT;
      end
    endcase
  end

  // Synchroniser and state registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
      state_reg <= lmc_pkg::LMC_AB_WAIT;
      cnt_reg <= '0;
      falls_reg <= '0;
      stat_reg <= '0;
    end
    else
    begin
      sync1_reg <= rx_i;
      sync2_reg <= sync1_reg;
      rx_prev_reg <= sync2_reg;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      falls_reg <= falls_next;
      stat_reg <= stat_next;
    end
  end

  assign stat_o = stat_reg;

endmodule // lmc_port

// [lmc_regs.svh]
`ifndef LMC_REGS_SVH
`define LMC_REGS_SVH

// Register indices; byte address is four times the index
`define LMC_IDX_W 14
`define LMC_IDX_STATUS0 14'h0f41
`define LMC_IDX_FUNC_CTL0 14'h0f42
`define LMC_IDX_LIN_CTL0 14'h0f43
`define LMC_IDX_LIN_CTL1 14'h0f4b
`define LMC_IDX_BIT_PERIOD0 14'h0f44
`define LMC_IDX_IRQ_STAT 14'h0f50
`define LMC_IDX_IRQ_MASK 14'h0f51
// Bit of the index that selects the second port
`define LMC_PORT_SEL_BIT 3

// Field positions of the LIN control register
`define LMC_LIN_MASTER_BIT 7
`define LMC_LIN_SLAVE_BIT 6
`define LMC_AB_EN_BIT 5
`define LMC_AB_IRQ_EN_BIT 4

// Field positions of the first control register
`define LMC_FSEL_MSB 7
`define LMC_FSEL_LSB 5
`define LMC_MULTIPROC_EN_BIT 4
`define LMC_PARITY_EN_BIT 3
`define LMC_FSEL_LIN 3'h2

// Status register field
`define LMC_AB_DONE_BIT 0

// Reset values
`define LMC_CTL_RESET 8'h00
`define LMC_WORD_RESET 32'h0000_0000

// Autobaud measurement counter; eight bit times are measured
`define LMC_CNT_W 19
`define LMC_CNT_MAX 19'h7_ffff
`define LMC_AB_FALLS 3'h4
`define LMC_PERIOD_SHIFT 3

`endif

// [lmc_top.sv]
// Register access over APB was decided locally.
`include "lmc_regs.svh"

// Overview of operation
// - LIN register mapped only in LIN function mode
// - Eight bit R/W, reset zero, one per port
// - Master bit selects master if others clear
// - Slave bit selects slave if others clear
// - Autobaud runs only when enabled in slave
// - Autobaud completion sets flag and raises interrupt only with interrupt enable set
module lmc_top
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] lin_rx_i,
  output logic irq_o,
  output logic [1:0] rx_irq_o,
  output logic [1:0] lin_master_o,
  output logic [1:0] lin_slave_o,
  output logic [1:0] autobaud_active_o
);

  localparam int unsigned NP = lmc_pkg::LMC_PORTS;

  // Per-port control bytes; alt is the scratch byte outside LIN mode
  logic [7:0] fctl_reg [NP];
  logic [7:0] fctl_next [NP];
  logic [7:0] lctl_reg [NP];
  logic [7:0] lctl_next [NP];
  logic [7:0] alt_reg [NP];
  logic [7:0] alt_next [NP];

  // Sticky autobaud flags, interrupt status and mask
  logic [NP-1:0] done_reg;
  logic [NP-1:0] done_next;
  logic [NP-1:0] istat_reg;
  logic [NP-1:0] istat_next;
  logic [NP-1:0] imask_reg;
  logic [NP-1:0] imask_next;

  // Bus answer, standing for one cycle only
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  // Interrupt output registers
  logic irq_reg;
  logic irq_next;
  logic [NP-1:0] rxirq_reg;
  logic [NP-1:0] rxirq_next;

  // Address decode
  logic [`LMC_IDX_W-1:0] idx;
  logic [`LMC_IDX_W-1:0] local_idx;
  logic port_sel;
  logic aligned;
  logic commit;
  logic wr;

  // Per-port configuration out, status back
  logic [NP-1:0] ab_event;
  lmc_pkg::lmc_port_cfg_s cfg [NP];
  lmc_pkg::lmc_port_stat_s stat [NP];

  // Word index and port split; bit 3 of the index picks the port
  assign idx = paddr_i[15:2];
  assign aligned = (paddr_i[1:0] == 2'h0);
  assign port_sel = idx[`LMC_PORT_SEL_BIT];
  assign local_idx = idx & ~(`LMC_IDX_W'(1) << `LMC_PORT_SEL_BIT);
  // Write lands at the edge where the master sees pready high
  assign commit = psel_i & penable_i & pready_reg;
  assign wr = commit & pwrite_i;

  // One LIN control block per serial port
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_port
      // Split the first control byte into its fields
      always_comb
      begin
        cfg[gp].fsel = fctl_reg[gp][`LMC_FSEL_MSB:`LMC_FSEL_LSB];
        cfg[gp].multiprocessor_enable = fctl_reg[gp][`LMC_MULTIPROC_EN_BIT];
        cfg[gp].parity_enable = fctl_reg[gp][`LMC_PARITY_EN_BIT];
        cfg[gp].lin_ctl = lctl_reg[gp];
      end

      lmc_port u_port
      (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .cfg_i(cfg[gp]),
        .rx_i(lin_rx_i[gp]),
        .stat_o(stat[gp])
      );

      // Role and autobaud outputs come straight from port registers
      assign ab_event[gp] = stat[gp].ab_event;
      assign lin_master_o[gp] = stat[gp].master;
      assign lin_slave_o[gp] = stat[gp].slave;
      assign autobaud_active_o[gp] = stat[gp].ab_active;
    end
  endgenerate

  // APB read path; answer is registered one cycle into the access phase
  always_comb
  begin
    prdata_next = `LMC_WORD_RESET;
    pslverr_next = 1'b0;
    pready_next = psel_i & penable_i & ~pready_reg;
    // Unaligned access is refused before any decode
    if (!aligned)
    begin
      pslverr_next = 1'b1;
    end
    else if (local_idx == `LMC_IDX_LIN_CTL0)
    begin
      // Same address shows another register outside LIN mode
      if (cfg[port_sel].fsel == `LMC_FSEL_LIN)
      begin
        prdata_next[7:0] = lctl_reg[port_sel];
      end
      else
      begin
        prdata_next[7:0] = alt_reg[port_sel];
      end
    end
    else if (local_idx == `LMC_IDX_FUNC_CTL0)
    begin
      prdata_next[7:0] = fctl_reg[port_sel];
    end
    else if (local_idx == `LMC_IDX_STATUS0)
    begin
      prdata_next[`LMC_AB_DONE_BIT] = done_reg[port_sel];
    end
    else if (local_idx == `LMC_IDX_BIT_PERIOD0)
    begin
      prdata_next[15:0] = stat[port_sel].bit_period;
    end
    else if (idx == `LMC_IDX_IRQ_STAT)
    begin
      prdata_next[NP-1:0] = istat_reg;
    end
    else if (idx == `LMC_IDX_IRQ_MASK)
    begin
      prdata_next[NP-1:0] = imask_reg;
    end
    else
    begin
      // Unmapped word answers with an error and zero data
      pslverr_next = 1'b1;
    end
    // Data and error only stand in the answer cycle
    if (!pready_next)
    begin
      prdata_next = `LMC_WORD_RESET;
      pslverr_next = 1'b0;
    end
  end

  // Register writes; hardware set wins over a same-cycle clear
  always_comb
  begin
    done_next = done_reg;
    istat_next = istat_reg;
    imask_next = imask_reg;
    for (int p = 0; p < NP; p++)
    begin
      fctl_next[p] = fctl_reg[p];
      lctl_next[p] = lctl_reg[p];
      alt_next[p] = alt_reg[p];
      if (wr && aligned && port_sel == p[0])
      begin
        if (local_idx == `LMC_IDX_LIN_CTL0)
        begin
          if (cfg[p].fsel == `LMC_FSEL_LIN)
          begin
            // Whole byte stored, link state and break length included
            lctl_next[p] = pwdata_i[7:0];
          end
          else
          begin
            alt_next[p] = pwdata_i[7:0];
          end
        end
        else if (local_idx == `LMC_IDX_FUNC_CTL0)
        begin
          fctl_next[p] = pwdata_i[7:0];
        end
        else if (local_idx == `LMC_IDX_STATUS0)
        begin
          done_next[p] = done_reg[p] & ~pwdata_i[`LMC_AB_DONE_BIT];
        end
      end
      // Writing a one clears the interrupt status bit
      if (wr && aligned && idx == `LMC_IDX_IRQ_STAT && pwdata_i[p])
      begin
        istat_next[p] = 1'b0;
      end
      if (ab_event[p])
      begin
        done_next[p] = 1'b1;
        istat_next[p] = 1'b1;
      end
    end
    // Mask is written whole
    if (wr && aligned && idx == `LMC_IDX_IRQ_MASK)
    begin
      imask_next = pwdata_i[NP-1:0];
    end
  end

  // Interrupt outputs are registered at the same edge as the sticky bits
  always_comb
  begin
    // Built from next values so irq rises with its status bit
    irq_next = |(istat_next & imask_next);
    for (int p = 0; p < NP; p++)
    begin
      // Receive interrupt stands while the autobaud flag and its interrupt enable bit are set
      rxirq_next[p] = done_next[p] & lctl_next[p][`LMC_AB_IRQ_EN_BIT];
    end
  end

  // Control bytes clear on reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int p = 0; p < NP; p++)
      begin
        fctl_reg[p] <= `LMC_CTL_RESET;
        lctl_reg[p] <= `LMC_CTL_RESET;
        alt_reg[p] <= `LMC_CTL_RESET;
      end
    end
    else
    begin
      for (int p = 0; p < NP; p++)
      begin
        fctl_reg[p] <= fctl_next[p];
        lctl_reg[p] <= lctl_next[p];
        alt_reg[p] <= alt_next[p];
      end
    end
  end

  // Flags, mask and interrupt outputs
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      done_reg <= '0;
      istat_reg <= '0;
      imask_reg <= '0;
      irq_reg <= 1'b0;
      rxirq_reg <= '0;
    end
    else
    begin
      done_reg <= done_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      irq_reg <= irq_next;
      rxirq_reg <= rxirq_next;
    end
  end

  // Bus answer; a pending answer is dropped on reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prdata_reg <= `LMC_WORD_RESET;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign irq_o = irq_reg;
  assign rx_irq_o = rxirq_reg;

endmodule // lmc_top

// [lmc_top_properties.sv]
module lmc_top_properties
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [1:0] lin_rx_i,
  input wire logic irq_o,
  input wire logic [1:0] rx_irq_o,
  input wire logic [1:0] lin_master_o,
  input wire logic [1:0] lin_slave_o,
  input wire logic [1:0] autobaud_active_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Bus timing: one wait state, one-cycle answer
  ready_one_wait_a: assert property ((psel_i && !penable_i) ##1 (psel_i && penable_i) |=> pready_o)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  err_zero_data_a: assert property (pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("refused access returned data");
  idle_zero_data_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside answer cycle");
  // Roles exclude each other; autobaud only as slave
  role_exclusive_a: assert property ((lin_master_o & lin_slave_o) == 2'b00)
    else $error("master and slave at once");
  autobaud_slave_a: assert property ((autobaud_active_o & ~lin_slave_o) == 2'b00)
    else $error("autobaud active outside slave role");
  // Flag is sticky until software writes
  rx_irq_sticky_a: assert property (rx_irq_o[0] && !(pwrite_i && penable_i)
    && !$past(pwrite_i && penable_i) |=> rx_irq_o[0])
    else $error("autobaud interrupt dropped by itself");

  cover property (pslverr_o);
  cover property ($rose(irq_o));
  cover property (lin_master_o[0]);
endmodule // lmc_top_properties

bind lmc_top lmc_top_properties i_lmc_top_properties (.ref_clk_i, .rst_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .lin_rx_i,
  .irq_o, .rx_irq_o, .lin_master_o, .lin_slave_o, .autobaud_active_o);

// [lmc_top_tb.sv]
`include "lmc_regs.svh"

module lmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ST0 = 16'(`LMC_IDX_STATUS0 * 4);
  localparam logic [15:0] FC = 16'(`LMC_IDX_FUNC_CTL0 * 4);
  localparam logic [15:0] LC = 16'(`LMC_IDX_LIN_CTL0 * 4);
  localparam logic [15:0] BP = 16'(`LMC_IDX_BIT_PERIOD0 * 4);
  localparam logic [15:0] IST = 16'(`LMC_IDX_IRQ_STAT * 4);
  localparam logic [15:0] IMK = 16'(`LMC_IDX_IRQ_MASK * 4);
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwr = 1'b0;
  logic [15:0] pa = 16'h0000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd;
  logic rdy;
  logic serr;
  logic line;
  logic irq;
  logic [1:0] rxi;
  logic [1:0] mst;
  logic [1:0] slv;
  logic [1:0] aba;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int num_checks = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  lmc_lin_node i_lmc_lin_node (.ref_clk_i(clk), .line_o(line));
  // Second port line idles high, untouched
  lmc_top i_lmc_top (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(serr), .lin_rx_i({1'b1, line}), .irq_o(irq), .rx_irq_o(rxi),
    .lin_master_o(mst), .lin_slave_o(slv), .autobaud_active_o(aba));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is sampled high; only the watchdog ends a wait
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (rdy !== 1'b1);
    rd = prd;
    err = serr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk(32'(err), 32'(e));
  endtask

  // Reset values, storage, mapping by function select
  task automatic t_map;
    rdchk(LC, 32'h0000_0000, 1'b0);
    rdchk(LC + 16'h0020, 32'h0000_0000, 1'b0);
    apb(1'b1, FC, 32'h0000_0040);
    apb(1'b1, LC, 32'h0000_00ff);
    rdchk(LC, 32'h0000_00ff, 1'b0);
    apb(1'b1, FC, 32'h0000_0000);
    rdchk(LC, 32'h0000_0000, 1'b0);
    apb(1'b1, LC, 32'h0000_005a);
    apb(1'b1, FC, 32'h0000_0040);
    rdchk(LC, 32'h0000_00ff, 1'b0);
    rdchk(16'h3f00, 32'h0000_0000, 1'b1);
    rdchk(LC + 16'h0002, 32'h0000_0000, 1'b1);
  endtask

  // Role qualification table: master, slave, autobaud
  task automatic t_roles;
    logic [7:0] f [7] = '{8'h40, 8'h40, 8'h40, 8'h50, 8'h48, 8'h40, 8'h40};
    logic [7:0] l [7] = '{8'h80, 8'h40, 8'hc0, 8'h80, 8'h40, 8'h60, 8'h20};
    logic [2:0] x [7] = '{3'h4, 3'h2, 3'h0, 3'h0, 3'h0, 3'h3, 3'h0};
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, FC, 32'(f[i]));
      apb(1'b1, LC, 32'(l[i]));
      repeat (2) @(posedge clk);
      chk(32'({mst[0], slv[0], aba[0]}), 32'(x[i]));
    end
  endtask

  // Sync character in and the flags that follow
  task automatic t_autobaud;
    apb(1'b1, IMK, 32'h0000_0001);
    apb(1'b1, LC, 32'h0000_0070);
    i_lmc_lin_node.send(16);
    for (int n = 0; n < 40 && irq !== 1'b1; n++)
      @(posedge clk);
    chk(32'({irq, rxi[0]}), 32'h0000_0003);
    rdchk(ST0, 32'h0000_0001, 1'b0);
    rdchk(BP, 32'h0000_0010, 1'b0);
    apb(1'b1, ST0, 32'h0000_0001);
    apb(1'b1, IST, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk(32'({irq, rxi[0]}), 32'h0000_0000);
    // Interrupt enable off: no flag
    apb(1'b1, LC, 32'h0000_0060);
    i_lmc_lin_node.send(16);
    repeat (20) @(posedge clk);
    rdchk(ST0, 32'h0000_0000, 1'b0);
    // Masked: status set, line quiet
    apb(1'b1, IMK, 32'h0000_0000);
    apb(1'b1, LC, 32'h0000_0070);
    i_lmc_lin_node.send(16);
    repeat (20) @(posedge clk);
    chk(32'({irq, rxi[0]}), 32'h0000_0001);
    rdchk(IST, 32'h0000_0001, 1'b0);
    apb(1'b1, ST0, 32'h0000_0001);
    // Autobaud without slave role stays idle
    apb(1'b1, LC, 32'h0000_0030);
    i_lmc_lin_node.send(16);
    repeat (20) @(posedge clk);
    rdchk(ST0, 32'h0000_0000, 1'b0);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_map();
    t_roles();
    t_autobaud();
    results();
  end

  // Watchdog at 10000 cycles, about ten times the cycles used
  initial
  begin
    #40000;
    n_fail++;
    results();
  end
endmodule // lmc_top_tb
